//--- design/watchdog_pkg.sv
// Purpose: shared constants for the independent watchdog timing core
// Assumes: kernel clock nominally 32 kHz, sampled by core_clk at 125 MHz
// Notes: prescaler codes above the table all select the largest divider
package watchdog_pkg;
   localparam int PRESCALER_SELECT_W = 4;
   localparam int RELOAD_W = 12;
   localparam int DIVIDER_W = 11;
   localparam int KERNEL_HZ = 32000;
   localparam logic [PRESCALER_SELECT_W-1:0] LAST_TABLE_CODE = 4'h7;
   // 1024 needs eleven bits, ten would wrap to zero
   localparam logic [DIVIDER_W-1:0] BASE_DIVIDER = 11'h004;
   localparam logic [DIVIDER_W-1:0] MAX_DIVIDER = 11'h400;
   localparam logic [DIVIDER_W-1:0] DIVIDER_ONE = 11'h001;
   localparam logic [RELOAD_W-1:0] RELOAD_MIN = 12'h002;
   localparam logic [RELOAD_W-1:0] RELOAD_MAX = 12'hfff;
   localparam logic [RELOAD_W-1:0] RELOAD_RESET = 12'hfff;
   localparam logic [PRESCALER_SELECT_W-1:0] PRESCALER_RESET = 4'h0;
   typedef enum logic [1:0] {
      WD_IDLE,
      WD_RUN,
      WD_EXPIRED
   } watchdog_state_t;
endpackage : watchdog_pkg

//--- design/kernel_edge_sync.sv
// Purpose: bring the kernel clock pin into core_clk and mark its rising edges
// Assumes: kernel clock far slower than core_clk
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
module kernel_edge_sync (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic pinIn,
   output logic risePulse
);
   logic meta_reg;
   logic sync_reg;
   logic last_reg;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         // all ones: a high pin at release gives no false edge, a lost edge only lengthens
         meta_reg <= 1'b1;
         sync_reg <= 1'b1;
         last_reg <= 1'b1;
      end else begin
         meta_reg <= pinIn;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end

   assign risePulse = sync_reg & ~last_reg;
endmodule : kernel_edge_sync

//--- design/independent_watchdog.sv
// Purpose: independent watchdog timing core, down counter driven by the kernel clock
// Assumes: start, refresh and configuration come from logic on core_clk
// Notes: requests take effect on the next kernel edge, so one kernel period of jitter
`timescale 1ns/1ps

// What this block does
// [RULE_01] codes 0-7 divide 4..512, others 1024
// [RULE_02] counting paced by independent 32 kHz kernel clock
// [RULE_03] reload is 12 bits, range 0x002 to 0xFFF
// [RULE_04] reload 0xFFF lasts 4096 prescaled ticks
// [RULE_05] up to one kernel period timing uncertainty
// [RULE_06] load, count down, reset at zero unless refreshed
module independent_watchdog (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic kernelClk,
   input wire logic start,
   input wire logic refresh,
   input wire logic [watchdog_pkg::PRESCALER_SELECT_W-1:0] prescalerSelect,
   input wire logic [watchdog_pkg::RELOAD_W-1:0] reloadValue,
   output logic resetRequest,
   output logic running,
   output logic [watchdog_pkg::RELOAD_W-1:0] counterValue
);
   import watchdog_pkg::*;

   logic kernelTick;
   watchdog_state_t state_reg;
   watchdog_state_t state_next;
   logic startPend_reg;
   logic refreshPend_reg;
   logic [DIVIDER_W-1:0] preCount_reg;
   logic [DIVIDER_W-1:0] divider;
   logic prescaledTick;
   logic [RELOAD_W-1:0] count_reg;
   logic [RELOAD_W-1:0] reloadLatch_reg;
   logic reset_reg;

   // the kernel clock is only sampled; no logic runs on it
   kernel_edge_sync kernelSync (
      .core_clk(core_clk),
      .rstn(rstn),
      .pinIn(kernelClk),
      .risePulse(kernelTick)
   ); // RULE_02

   // prescaler decode
   always_comb begin
      if (prescalerSelect <= LAST_TABLE_CODE) begin
         divider = BASE_DIVIDER << prescalerSelect[2:0]; // RULE_01
      end else begin
         divider = MAX_DIVIDER; // RULE_01
      end
   end

   // requests wait for the next kernel edge; set wins over that edge's clear
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         startPend_reg <= 1'b0;
         refreshPend_reg <= 1'b0;
      end else begin
         startPend_reg <= start | (startPend_reg & ~kernelTick); // RULE_05
         refreshPend_reg <= refresh | (refreshPend_reg & ~kernelTick); // RULE_05
      end
   end

   // reload value is caught at the kernel edge that applies it
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         reloadLatch_reg <= RELOAD_RESET;
      end else if (kernelTick && (startPend_reg || refreshPend_reg)) begin
         reloadLatch_reg <= reloadValue; // RULE_03
      end
   end

   // prescaler counts kernel edges; a reload restarts it so refresh gives a full period
   assign prescaledTick = kernelTick && (state_reg == WD_RUN)
                          && (preCount_reg == divider - DIVIDER_ONE);

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         preCount_reg <= '0;
      end else if (kernelTick) begin
         if (startPend_reg || refreshPend_reg || prescaledTick) begin
            preCount_reg <= '0;
         end else if (state_reg == WD_RUN) begin
            preCount_reg <= preCount_reg + DIVIDER_ONE;
         end
      end
   end

   // state
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         WD_IDLE: begin
            if (kernelTick && startPend_reg) begin
               state_next = WD_RUN;
            end
         end
         WD_RUN: begin
            if (prescaledTick && !refreshPend_reg && count_reg == '0) begin
               state_next = WD_EXPIRED; // RULE_06
            end
         end
         default: begin
            state_next = WD_EXPIRED;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= WD_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // down counter: reload 0xfff counts 0xfff..0 then expires, 4096 ticks
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         count_reg <= RELOAD_RESET;
      end else if (kernelTick && (startPend_reg || refreshPend_reg)) begin
         count_reg <= reloadValue; // RULE_06
      end else if (prescaledTick && count_reg != '0) begin
         count_reg <= count_reg - 12'h001; // RULE_04
      end
   end

   // reset request holds until the system reset clears the core
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         reset_reg <= 1'b0;
      end else if (state_next == WD_EXPIRED) begin
         reset_reg <= 1'b1; // RULE_06
      end
   end

   assign resetRequest = reset_reg;
   assign running = (state_reg == WD_RUN);
   assign counterValue = count_reg;
endmodule : independent_watchdog

//--- verif/kernel_clock_model.sv
// Purpose: kernel clock source for the watchdog
// Assumes: bench core clock period 8 ns
// Notes: free running, a fast stand-in for 32 kHz
`timescale 1ns/1ps
module kernel_clock_model (
   output logic kernelClk
);
   initial kernelClk = 1'b0;
   always #32 kernelClk = ~kernelClk;
endmodule : kernel_clock_model

//--- verif/independent_watchdog_chk.sv
// Purpose: port checks of the watchdog core
// Assumes: kernel period 8 core cycles
// Notes: arm bound follows the bench kernel rate
`timescale 1ns/1ps
module independent_watchdog_chk import watchdog_pkg::*; (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic start,
   input wire logic [RELOAD_W-1:0] reloadValue,
   input wire logic resetRequest,
   input wire logic running,
   input wire logic [RELOAD_W-1:0] counterValue
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   req_stops_run_a: assert property (resetRequest |-> !running)
      else $error("running after reset request");
   req_sticky_a: assert property (resetRequest |=> resetRequest)
      else $error("reset request dropped");
   load_reload_a: assert property ($rose(running) |-> counterValue == reloadValue)
      else $error("wrong load value");
   step_down_a: assert property (running && $past(running) && counterValue < $past(counterValue)
      |-> counterValue == $past(counterValue) - 12'h001) else $error("bad count step");
   kernel_paced_a: assert property ($changed(counterValue) |=> $stable(counterValue)[*4])
      else $error("count faster than kernel");
   start_arms_a: assert property (start && !resetRequest && !running |-> ##[1:14] running)
      else $error("start not applied");
   expire_zero_a: assert property ($rose(resetRequest) |-> counterValue == 12'h000)
      else $error("expiry off zero");
endmodule : independent_watchdog_chk
bind independent_watchdog independent_watchdog_chk i_independent_watchdog_chk (.core_clk, .rstn,
   .start, .reloadValue, .resetRequest, .running, .counterValue);

//--- verif/tb_independent_watchdog.sv
// Purpose: self-checking bench of the watchdog core
// Assumes: kernel period 8 core cycles
// Notes: reload 0xfff at /4 is too long to run here
`timescale 1ns/1ps
module tb_independent_watchdog;
   import watchdog_pkg::*;
   logic core_clk = 0, rstn = 0, kernelClk, start = 0, refresh = 0, resetRequest, running;
   logic [3:0] prescalerSelect = 0;
   logic [11:0] reloadValue = RELOAD_MIN, counterValue;
   int n_mismatch = 0, cmp_count = 0;
   always #4 core_clk = ~core_clk;
   kernel_clock_model i_kernel_clock_model (.kernelClk(kernelClk));
   independent_watchdog i_independent_watchdog (.core_clk, .rstn, .kernelClk, .start, .refresh,
      .prescalerSelect, .reloadValue, .resetRequest, .running, .counterValue);
   task automatic end_of_test;
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : end_of_test
   task automatic cmp_range(input int got, input int lo, input int hi);
      cmp_count++;
      if (got < lo || got > hi) begin
         n_mismatch++;
         $display("mismatch %0t %h %h", $time, got, lo);
      end
   endtask : cmp_range
   task automatic cmp_val(input logic [11:0] got, input logic [11:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch %0t %h %h", $time, got, exp);
      end
   endtask : cmp_val
   task automatic arm(input logic [3:0] code, input logic [11:0] rl);
      rstn <= 0;
      repeat (5) @(posedge core_clk);
      rstn <= 1;
      prescalerSelect <= code;
      reloadValue <= rl;
      @(posedge core_clk) start <= 1;
      @(posedge core_clk) start <= 0;
   endtask : arm
   // counts cycles until expiry, measured from the call, which follows the start pulse or the last refresh
   task automatic expire(inout int n);
      while (resetRequest !== 1'b1) begin
         @(posedge core_clk) n++;
         if (n > 30000) begin
            n_mismatch++;
            end_of_test();
         end
      end
   endtask : expire
   task automatic t_prescale;
      int codes[5] = '{0, 3, 7, 8, 15};
      int n, span;
      foreach (codes[i]) begin
         arm(codes[i], RELOAD_MIN);
         n = 0;
         expire(n);
         // three prescaled ticks for reload 2, plus sync slack
         span = 24 * (codes[i] > 7 ? 1024 : 4 << codes[i]);
         cmp_range(n, span, span + 24);
         cmp_val(counterValue, 12'h000);
         cmp_val({11'h000, running}, 12'h000);
      end
      $display("t_prescale done");
   endtask : t_prescale
   task automatic t_refresh;
      int n;
      arm(0, 12'h00a);
      repeat (6) begin
         repeat (200) @(posedge core_clk);
         refresh <= 1;
         @(posedge core_clk) refresh <= 0;
      end
      cmp_val({11'h000, resetRequest}, 12'h000);
      cmp_val({11'h000, running}, 12'h001);
      n = 0;
      expire(n);
      cmp_range(n, 352, 376);
      $display("t_refresh done");
   endtask : t_refresh
   initial begin
      t_prescale();
      t_refresh();
      end_of_test();
   end
endmodule : tb_independent_watchdog
